/* hdl/svm_top.sv */
`timescale 1ns/1ns
// ============================================================
// Supply voltage monitor control with AXI4-Lite registers
module svm_top
  import svm_pkg::*;
#(
  parameter int ADDR_W = 4
)
(
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address
  input wire logic awvalid,
  output logic awready,
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic [2:0] awprot,
  // AXI4-Lite write data
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  // AXI4-Lite write response
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // AXI4-Lite read address
  input wire logic arvalid,
  output logic arready,
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic [2:0] arprot,
  // AXI4-Lite read data
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  // Comparator side, asynchronous
  input wire logic cmp_below_fall,
  input wire logic cmp_above_rise,
  // Device stopped, same clock domain
  input wire logic stop_mode,
  // Controls to the analog part and the system
  output logic monitor_power_enable,
  output logic trip_high_select,
  output logic reset_request,
  output logic below_threshold_flag,
  output logic irq
);

  // Elaboration check
  if (ADDR_W < 4)
  begin : g_chk
    $error("svm_top: ADDR_W must be at least 4");
  end

  // ==========================================================
  // Declarations
  logic [1:0] cmp_s;           // Synchronised comparator outputs
  logic below_s;               // Supply below selected falling trip
  logic above_s;               // Supply above selected rising trip
  logic pwrd_q;                // monitor_power_disable
  logic rstd_q;                // monitor_reset_disable
  logic stop_en_q;             // monitor_stop_enable
  logic hts_q;                 // high_threshold_select
  logic [1:0] hts_dly_q;       // Select delayed by the synchroniser depth
  logic hts_prev_q;            // Delayed select one cycle later, for the rise
  logic hts_rise;              // Select went high and the comparator now judges the new level
  logic active;                // Monitor powered and allowed to run
  svm_state_e state_q;         // Monitor state
  svm_state_e state_d;         // Next monitor state
  logic flag_q;                // below_threshold_flag register
  logic rst_q;                 // Reset request register
  logic pwr_q;                 // Power enable register
  logic [SVM_EV_W-1:0] ists_q; // Sticky events
  logic [SVM_EV_W-1:0] imsk_q; // Event mask
  logic [SVM_EV_W-1:0] ev;     // Events this cycle
  logic irq_q;                 // Interrupt output register
  logic awready_q;             // Write address ready
  logic wready_q;              // Write data ready
  logic aw_full_q;             // Write address held
  logic w_full_q;              // Write data held
  logic [ADDR_W-1:0] waddr_q;  // Held write address
  logic [31:0] wdata_q;        // Held write data
  logic wstrb0_q;              // Held low byte strobe
  logic bvalid_q;              // Write response valid
  logic [1:0] bresp_q;         // Write response code
  logic arready_q;             // Read address ready
  logic rvalid_q;              // Read data valid
  logic [31:0] rdata_q;        // Read data
  logic [1:0] rresp_q;         // Read response code
  logic wr_do;                 // Register write happens now
  logic wr_cfg;                // Write hits configuration
  logic wr_ists;               // Write hits interrupt status
  logic wr_imsk;               // Write hits interrupt mask

  // ==========================================================
  // Decoding shared by reads and writes
  function automatic logic [1:0] reg_sel(input logic [ADDR_W-1:0] a);
    logic [1:0] s;
    s = a[3:2];
    return s;
  endfunction

  function automatic logic reg_hit(input logic [ADDR_W-1:0] a);
    logic ok;
    ok = (a[1:0] == 2'h0);
    if (ADDR_W > 4)
    begin
      ok = ok && ((a >> 4) == '0);
    end
    return ok;
  endfunction

  // ==========================================================
  // Comparator synchronisation
  // Comparators change with the supply, not the clock
  svm_sync #(
    .WIDTH(2)
  ) u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .async_in({cmp_above_rise, cmp_below_fall}),
    .sync_out(cmp_s)
  );
  assign below_s = cmp_s[0];
  assign above_s = cmp_s[1];

  // ==========================================================
  // Monitor gating
  // Powered unless disabled; stopped device needs stop enable
  assign active = !pwrd_q && (!stop_mode || stop_en_q);
  assign hts_rise = hts_dly_q[1] && !hts_prev_q;

  // ==========================================================
  // Write decode
  assign wr_do = aw_full_q && w_full_q && !bvalid_q;
  assign wr_cfg = wr_do && wstrb0_q && reg_hit(waddr_q) && (reg_sel(waddr_q) == SVM_CFG_OFF[3:2]);
  assign wr_ists = wr_do && wstrb0_q && reg_hit(waddr_q) && (reg_sel(waddr_q) == SVM_ISTS_OFF[3:2]);
  assign wr_imsk = wr_do && wstrb0_q && reg_hit(waddr_q) && (reg_sel(waddr_q) == SVM_IMSK_OFF[3:2]);

  // Configuration bits; all clear so the monitor runs from reset
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      pwrd_q <= SVM_CFG_RST[SVM_CFG_PWRD];
      rstd_q <= SVM_CFG_RST[SVM_CFG_RSTD];
      stop_en_q <= SVM_CFG_RST[SVM_CFG_STOP];
      hts_q <= SVM_CFG_RST[SVM_CFG_HTS];
    end
    else if (wr_cfg)
    begin
      // Threshold and reset enable are separate fields
      pwrd_q <= wdata_q[SVM_CFG_PWRD];
      rstd_q <= wdata_q[SVM_CFG_RSTD];
      stop_en_q <= wdata_q[SVM_CFG_STOP];
      hts_q <= wdata_q[SVM_CFG_HTS];
    end
  end

  // Delayed select, to spot software raising the level
  // The comparator answer for the new level needs two synchroniser stages;
  // judging the rise earlier would use the old level's verdict
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      hts_dly_q <= 2'h0;
      hts_prev_q <= 1'b0;
    end
    else
    begin
      hts_dly_q <= {hts_dly_q[0], hts_q};
      hts_prev_q <= hts_dly_q[1];
    end
  end

  // ==========================================================
  // Monitor state machine
  always_comb
  begin
    state_d = state_q;
    case (state_q)
      SVM_OFF:
      begin
        // Wake when powered and allowed
        if (active)
        begin
          state_d = SVM_WATCH;
        end
      end
      SVM_WATCH:
      begin
        if (!active)
        begin
          state_d = SVM_OFF;
        end
        else if (!rstd_q && (below_s || (hts_rise && !above_s)))
        begin
          // Falling trip, or higher level chosen too late
          state_d = SVM_HOLD;
        end
      end
      SVM_HOLD:
      begin
        // Released only above the rising trip while active, giving hysteresis
        if (!active)
        begin
          state_d = SVM_OFF;
        end
        else if (above_s)
        begin
          state_d = SVM_WATCH;
        end
      end
      default:
      begin
        state_d = SVM_OFF;
      end
    endcase
  end

  // State register
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state_q <= SVM_OFF;
    end
    else
    begin
      state_q <= state_d;
    end
  end

  // Output registers of the monitor
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rst_q <= 1'b0;
      pwr_q <= 1'b0;
      flag_q <= 1'b0;
    end
    else
    begin
      rst_q <= (state_d == SVM_HOLD);
      pwr_q <= !pwrd_q;
      // Flag shows the comparator only while it is meaningful
      flag_q <= active && below_s;
    end
  end

  // ==========================================================
  // Interrupt status and mask
  assign ev[SVM_EV_BELOW] = active && below_s && !flag_q;
  assign ev[SVM_EV_RST] = (state_d == SVM_HOLD) && !rst_q;

  // Sticky bits; an event in the clearing cycle survives
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ists_q <= '0;
    end
    else if (wr_ists)
    begin
      ists_q <= (ists_q & ~wdata_q[SVM_EV_W-1:0]) | ev;
    end
    else
    begin
      ists_q <= ists_q | ev;
    end
  end

  // Mask register
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      imsk_q <= SVM_IMSK_RST;
    end
    else if (wr_imsk)
    begin
      imsk_q <= wdata_q[SVM_EV_W-1:0];
    end
  end

  // Interrupt line, one cycle behind the status
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      irq_q <= 1'b0;
    end
    else
    begin
      irq_q <= |(ists_q & imsk_q);
    end
  end

  // ==========================================================
  // AXI4-Lite write channels
  // Address and data are taken in either order, one write at a time
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      awready_q <= 1'b0;
      aw_full_q <= 1'b0;
      waddr_q <= '0;
    end
    else if (awvalid && awready_q)
    begin
      awready_q <= 1'b0;
      aw_full_q <= 1'b1;
      waddr_q <= awaddr;
    end
    else if (wr_do)
    begin
      aw_full_q <= 1'b0;
    end
    else if (!aw_full_q && !bvalid_q)
    begin
      awready_q <= 1'b1;
    end
  end

  // Write data holder
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      wready_q <= 1'b0;
      w_full_q <= 1'b0;
      wdata_q <= '0;
      wstrb0_q <= 1'b0;
    end
    else if (wvalid && wready_q)
    begin
      wready_q <= 1'b0;
      w_full_q <= 1'b1;
      wdata_q <= wdata;
      wstrb0_q <= wstrb[0];
    end
    else if (wr_do)
    begin
      w_full_q <= 1'b0;
    end
    else if (!w_full_q && !bvalid_q)
    begin
      wready_q <= 1'b1;
    end
  end

  // Write response; unmapped or read-only targets answer SLVERR
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      bvalid_q <= 1'b0;
      bresp_q <= SVM_RESP_OKAY;
    end
    else if (wr_do)
    begin
      bvalid_q <= 1'b1;
      if (reg_hit(waddr_q) && (reg_sel(waddr_q) != SVM_STS_OFF[3:2]))
      begin
        bresp_q <= SVM_RESP_OKAY;
      end
      else
      begin
        bresp_q <= SVM_RESP_SLVERR;
      end
    end
    else if (bvalid_q && bready)
    begin
      bvalid_q <= 1'b0;
    end
  end

  // ==========================================================
  // AXI4-Lite read channels
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      arready_q <= 1'b0;
      rvalid_q <= 1'b0;
      rdata_q <= '0;
      rresp_q <= SVM_RESP_OKAY;
    end
    else if (arvalid && arready_q)
    begin
      arready_q <= 1'b0;
      rvalid_q <= 1'b1;
      rresp_q <= reg_hit(araddr) ? SVM_RESP_OKAY : SVM_RESP_SLVERR;
      rdata_q <= '0;
      if (reg_hit(araddr))
      begin
        case (reg_sel(araddr))
          SVM_CFG_OFF[3:2]: rdata_q[3:0] <= {hts_q, stop_en_q, rstd_q, pwrd_q};
          SVM_STS_OFF[3:2]: rdata_q[3:0] <= {above_s, active, rst_q, flag_q};
          SVM_ISTS_OFF[3:2]: rdata_q[SVM_EV_W-1:0] <= ists_q;
          default: rdata_q[SVM_EV_W-1:0] <= imsk_q;
        endcase
      end
    end
    else if (rvalid_q && rready)
    begin
      rvalid_q <= 1'b0;
    end
    else if (!rvalid_q)
    begin
      arready_q <= 1'b1;
    end
  end

  // ==========================================================
  // Port drive, all from flip-flops
  assign awready = awready_q;
  assign wready = wready_q;
  assign bvalid = bvalid_q;
  assign bresp = bresp_q;
  assign arready = arready_q;
  assign rvalid = rvalid_q;
  assign rdata = rdata_q;
  assign rresp = rresp_q;
  assign monitor_power_enable = pwr_q;
  assign trip_high_select = hts_q;
  assign reset_request = rst_q;
  assign below_threshold_flag = flag_q;
  assign irq = irq_q;

  // ==========================================================
  // Assertions
  a_reset_defaults: assert property (@(posedge aclk) disable iff (!aresetn)
    !$past(aresetn) |-> (!pwrd_q && !rstd_q && !hts_q))
    else $error("monitor not enabled at low level after reset");

  a_power_gate: assert property (@(posedge aclk) disable iff (!aresetn)
    pwrd_q |=> (!monitor_power_enable && !below_threshold_flag && !reset_request))
    else $error("disabled monitor still acting");

  a_fall_reset: assert property (@(posedge aclk) disable iff (!aresetn)
    (state_q == SVM_WATCH && active && !rstd_q && below_s) |=> reset_request)
    else $error("falling trip gave no reset request");

  a_stop_idle: assert property (@(posedge aclk) disable iff (!aresetn)
    (stop_mode && !stop_en_q) |=> (!below_threshold_flag && !reset_request))
    else $error("monitor active in stop without enable");

  a_hts_write: assert property (@(posedge aclk) disable iff (!aresetn)
    (wr_cfg && wdata_q[SVM_CFG_HTS]) |=> trip_high_select)
    else $error("high threshold select not applied");

  a_hts_late: assert property (@(posedge aclk) disable iff (!aresetn)
    (state_q == SVM_WATCH && active && !rstd_q && hts_rise && !above_s) |=> reset_request)
    else $error("late high level select did not reset");

  a_hyst_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    (reset_request && state_q == SVM_HOLD && active && !above_s) |=> reset_request)
    else $error("reset released below rising trip");

  a_flag_track: assert property (@(posedge aclk) disable iff (!aresetn)
    active |=> (below_threshold_flag == $past(below_s)))
    else $error("flag does not follow comparator");

  a_no_reset_polled: assert property (@(posedge aclk) disable iff (!aresetn)
    (rstd_q && state_q != SVM_HOLD) |=> !reset_request)
    else $error("reset raised while resets disabled");

  a_sync_depth: assert property (@(posedge aclk) disable iff (!aresetn)
    $past(aresetn, 2) |-> (below_s == $past(cmp_below_fall, 2)))
    else $error("comparator not delayed by two stages");

endmodule

/* hdl/svm_pkg.sv */
package svm_pkg;

  // ==========================================================
  // Register byte offsets
  localparam logic [3:0] SVM_CFG_OFF = 4'h0;   // Configuration
  localparam logic [3:0] SVM_STS_OFF = 4'h4;   // Monitor status, read only
  localparam logic [3:0] SVM_ISTS_OFF = 4'h8;  // Interrupt status, write one to clear
  localparam logic [3:0] SVM_IMSK_OFF = 4'hc;  // Interrupt mask

  // ==========================================================
  // Configuration field positions
  localparam int SVM_CFG_PWRD = 0;  // Monitor power disable
  localparam int SVM_CFG_RSTD = 1;  // Monitor reset disable
  localparam int SVM_CFG_STOP = 2;  // Operate in stop mode
  localparam int SVM_CFG_HTS = 3;   // High threshold select

  // Status field positions
  localparam int SVM_STS_BELOW = 0;  // Below threshold flag
  localparam int SVM_STS_RST = 1;    // Reset request active
  localparam int SVM_STS_ACT = 2;    // Monitor operating
  localparam int SVM_STS_ABOVE = 3;  // Supply above rising trip

  // Interrupt event positions
  localparam int SVM_EV_BELOW = 0;  // Flag went high
  localparam int SVM_EV_RST = 1;    // Reset request went high
  localparam int SVM_EV_W = 2;      // Number of events

  // ==========================================================
  // Reset values
  localparam logic [3:0] SVM_CFG_RST = 4'h0;  // Monitor and resets enabled, stop operation off, low trip level
  localparam logic [1:0] SVM_IMSK_RST = 2'h0; // Interrupts masked

  // AXI responses
  localparam logic [1:0] SVM_RESP_OKAY = 2'h0;
  localparam logic [1:0] SVM_RESP_SLVERR = 2'h2;

  // Monitor states
  typedef enum logic [1:0] {SVM_OFF, SVM_WATCH, SVM_HOLD} svm_state_e;

endpackage

/* hdl/svm_sync.sv */
`timescale 1ns/1ns
// ============================================================
// Two flip-flop synchroniser, one chain per bit
module svm_sync
  import svm_pkg::*;
#(
  parameter int WIDTH = 2
)
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  // Elaboration check
  if (WIDTH < 1)
  begin : g_chk
    $error("svm_sync: WIDTH must be at least 1");
  end

  genvar i;
  for (i = 0; i < WIDTH; i++)
  begin : g_bit
    logic meta_q; // First stage, read only by second stage
    logic stab_q; // Second stage, safe to use

    // Chain of two; a metastable first stage settles before use
    always_ff @(posedge aclk)
    begin
      if (!aresetn)
      begin
        meta_q <= 1'b0;
        stab_q <= 1'b0;
      end
      else
      begin
        meta_q <= async_in[i];
        stab_q <= meta_q;
      end
    end
    assign sync_out[i] = stab_q;
  end

endmodule

/* sim/svm_cmp_model.sv */
`timescale 1ns/1ns
// ============================================================
// Behavioural comparator pair that senses the supply in mV
module svm_cmp_model
#(
  parameter int LO_FALL = 2400,  // Lower level, falling trip
  parameter int LO_RISE = 2500,  // Lower level, rising trip
  parameter int HI_FALL = 2600,  // Higher level, falling trip
  parameter int HI_RISE = 2700   // Higher level, rising trip
)
(
  input wire logic [15:0] supply_mv,
  input wire logic power_en,
  input wire logic high_sel,
  output logic below_fall,
  output logic above_rise
);
  int fall_mv;  // Falling trip in use
  int rise_mv;  // Rising trip in use

  // ==========================================================
  // Level pair follows the select line with no delay
  always_comb
  begin
    fall_mv = high_sel ? HI_FALL : LO_FALL;
    rise_mv = high_sel ? HI_RISE : LO_RISE;
    // An unpowered bandgap gives no decision, so both outputs rest low
    below_fall = power_en && (int'(supply_mv) < fall_mv);
    above_rise = power_en && (int'(supply_mv) > rise_mv);
  end
endmodule

/* sim/svm_top_tb.sv */
`timescale 1ns/1ns
// ============================================================
// Self-checking bench for the supply monitor
module svm_top_tb
  import svm_pkg::*;
;
  localparam int LO_FALL = 2400;  // Trip levels handed to the model
  localparam int LO_RISE = 2500;
  localparam int HI_FALL = 2600;
  localparam int HI_RISE = 2700;
  logic aclk = 1'b0;  // 50 ns clock
  logic aresetn = 1'b0;  // Held low at start
  logic awvalid = 1'b0, awready, wvalid = 1'b0, wready, bvalid, bready = 1'b0;
  logic arvalid = 1'b0, arready, rvalid, rready = 1'b0;
  logic [3:0] awaddr = 4'h0, araddr = 4'h0, wstrb = 4'hf;
  logic [31:0] wdata = 32'h0, rdata, rd;
  logic [1:0] bresp, rresp, resp;
  logic cmp_below_fall, cmp_above_rise, monitor_power_enable, trip_high_select;
  logic reset_request, below_threshold_flag, irq;
  logic stop_mode = 1'b0;  // Device stopped
  logic [15:0] supply_mv = 16'd3000;  // Supply seen by the model
  logic [15:0] seed = 16'd26;  // Random state
  int fail_count = 0, n_checks = 0, cycles = 0;

  always #25 aclk = ~aclk;

  svm_top uut (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
    .awprot(3'h0), .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid),
    .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr), .arprot(3'h0),
    .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp), .cmp_below_fall(cmp_below_fall),
    .cmp_above_rise(cmp_above_rise), .stop_mode(stop_mode), .monitor_power_enable(monitor_power_enable),
    .trip_high_select(trip_high_select), .reset_request(reset_request),
    .below_threshold_flag(below_threshold_flag), .irq(irq));

  svm_cmp_model #(.LO_FALL(LO_FALL), .LO_RISE(LO_RISE), .HI_FALL(HI_FALL), .HI_RISE(HI_RISE)) cmp (
    .supply_mv(supply_mv), .power_en(monitor_power_enable), .high_sel(trip_high_select),
    .below_fall(cmp_below_fall), .above_rise(cmp_above_rise));

  // ==========================================================
  // Verdict, reached from the main sequence or the watchdog
  task automatic close_out;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // Watchdog: the whole run needs far fewer cycles than this
  always @(posedge aclk)
  begin
    cycles++;
    if (cycles > 20000)
    begin
      fail_count++;
      close_out();
    end
  end

  // ==========================================================
  // Compare tasks, one per kind of result
  task automatic chk_bit(input logic got, input logic exp);
    n_checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask

  // Expected flag from the levels; stopped device idles unless allowed
  function automatic logic exp_flag(input int v, input logic hs, input logic st, input logic se);
    return (!st || se) && (v < (hs ? HI_FALL : LO_FALL));
  endfunction

  // Sixteen-bit Galois shift register
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return s[0] ? ((s >> 1) ^ 16'hb400) : (s >> 1);
  endfunction

  // ==========================================================
  // AXI4-Lite master; valids held until their ready is sampled
  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge aclk);
    awvalid <= 1'b1;
    awaddr <= a;
    wvalid <= 1'b1;
    wdata <= d;
    bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (awready)
        awvalid <= 1'b0;
      if (wready)
        wvalid <= 1'b0;
    end while (!bvalid);
    resp = bresp;
    bready <= 1'b0;
  endtask

  task automatic axi_rd(input logic [3:0] a);
    @(posedge aclk);
    arvalid <= 1'b1;
    araddr <= a;
    rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (arready)
        arvalid <= 1'b0;
    end while (!rvalid);
    rd = rdata;
    resp = rresp;
    rready <= 1'b0;
  endtask

  // Config write; field order is high select, stop, reset off, power off
  task automatic cfg(input logic [3:0] v);
    axi_wr(SVM_CFG_OFF, {28'h0, v});
  endtask

  // Move the supply; returns one edge later, before the flag can follow
  task automatic sup(input logic [15:0] v);
    @(posedge aclk);
    supply_mv <= v;
    @(posedge aclk);
    #1;
  endtask

  // Synchroniser and flag register have settled after this
  task automatic settle;
    repeat (6) @(posedge aclk);
    #1;
  endtask

  // ==========================================================
  // Main sequence
  initial
  begin
    logic hs, se, st;
    int v;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    settle();
    // Out of reset the monitor is on, at the lower level
    chk_bit(monitor_power_enable, 1'b1);
    chk_bit(trip_high_select, 1'b0);
    axi_rd(SVM_CFG_OFF);
    chk_word(rd, 32'h0);
    axi_rd(SVM_STS_OFF);
    chk_word(rd, (32'h1 << SVM_STS_ACT) | (32'h1 << SVM_STS_ABOVE));
    // Forced reset, then the hysteresis band
    sup(16'd2300);
    settle();
    chk_bit(reset_request, 1'b1);
    chk_bit(below_threshold_flag, 1'b1);
    chk_bit(irq, 1'b0);
    axi_rd(SVM_ISTS_OFF);
    chk_word(rd, 32'h3);
    sup(16'd2450);
    settle();
    chk_bit(reset_request, 1'b1);
    sup(16'd2550);
    settle();
    chk_bit(reset_request, 1'b0);
    axi_wr(SVM_ISTS_OFF, 32'h3);
    axi_rd(SVM_ISTS_OFF);
    chk_word(rd, 32'h0);
    // Refused accesses leave the registers alone
    axi_wr(SVM_STS_OFF, 32'h1);
    chk_word({30'h0, resp}, {30'h0, SVM_RESP_SLVERR});
    axi_rd(4'h2);
    chk_word({30'h0, resp}, {30'h0, SVM_RESP_SLVERR});
    chk_word(rd, 32'h0);
    // Low byte strobe off: answered OKAY, configuration untouched
    wstrb <= 4'he;
    cfg(4'h1);
    wstrb <= 4'hf;
    chk_word({30'h0, resp}, {30'h0, SVM_RESP_OKAY});
    axi_rd(SVM_CFG_OFF);
    chk_word(rd, 32'h0);
    // Polled use with the flag interrupt unmasked
    cfg(4'h2);
    axi_wr(SVM_IMSK_OFF, 32'h1);
    sup(16'd2300);
    chk_bit(below_threshold_flag, 1'b0);
    settle();
    chk_bit(below_threshold_flag, 1'b1);
    chk_bit(reset_request, 1'b0);
    chk_bit(irq, 1'b1);
    axi_wr(SVM_ISTS_OFF, 32'h1);
    settle();
    chk_bit(irq, 1'b0);
    sup(16'd3000);
    axi_wr(SVM_IMSK_OFF, 32'h0);
    // Powered down monitor ignores the supply
    cfg(4'h1);
    sup(16'd2300);
    settle();
    chk_bit(monitor_power_enable, 1'b0);
    chk_bit(below_threshold_flag, 1'b0);
    chk_bit(reset_request, 1'b0);
    // Stopped device, with and without stop operation
    cfg(4'h2);
    stop_mode <= 1'b1;
    settle();
    chk_bit(below_threshold_flag, 1'b0);
    cfg(4'h6);
    settle();
    chk_bit(below_threshold_flag, 1'b1);
    stop_mode <= 1'b0;
    // Higher level chosen while inside its band resets at once
    cfg(4'h0);
    sup(16'd2650);
    settle();
    chk_bit(reset_request, 1'b0);
    cfg(4'h8);
    settle();
    chk_bit(trip_high_select, 1'b1);
    chk_bit(reset_request, 1'b1);
    sup(16'd2800);
    settle();
    chk_bit(reset_request, 1'b0);
    sup(16'd2550);
    settle();
    chk_bit(reset_request, 1'b1);
    sup(16'd2800);
    settle();
    // Random polled sweep over levels and stop gating
    repeat (16)
    begin
      seed = lfsr(seed);
      v = 2200 + int'(seed % 16'd700);
      hs = seed[0];
      se = seed[1];
      st = seed[2];
      cfg({hs, se, 1'b1, 1'b0});
      @(posedge aclk);
      stop_mode <= st;
      sup(v[15:0]);
      settle();
      chk_bit(trip_high_select, hs);
      chk_bit(below_threshold_flag, exp_flag(v, hs, st, se));
      chk_bit(reset_request, 1'b0);
    end
    // Mid-run reset brings back the enabled, low-level defaults
    cfg(4'hf);
    stop_mode <= 1'b0;
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    settle();
    chk_bit(monitor_power_enable, 1'b1);
    chk_bit(trip_high_select, 1'b0);
    axi_rd(SVM_CFG_OFF);
    chk_word(rd, 32'h0);
    close_out();
  end
endmodule
